// >>> rtl/pwr_seq_pkg.sv
// package for the power-on sequencer: states, timing counts, carriers
// assumes a 20 MHz system clock, divided down for the 32.768 kHz rtc tick
package pwr_seq_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned RTC_HZ          = 32768;
  localparam int unsigned POWER_ON_REQUEST_LOW_MIN_US   = 5000;
  // least time: round up in rtc ticks
  localparam int unsigned POWER_ON_REQUEST_LOW_TICKS    =
    (POWER_ON_REQUEST_LOW_MIN_US * RTC_HZ + 999999) / 1000000;
  // rtc tick divider from the system clock, rounded down
  localparam int unsigned RTC_DIV         = CLK_HZ / RTC_HZ;
  localparam int unsigned REG_STEP_CYC    = 64;
  localparam int unsigned RST_HOLD_CYC    = 2000;
  localparam int unsigned CFG_STEP_CYC    = 16;
  localparam int unsigned NUM_REGS        = 4;
  localparam int unsigned NUM_IFS         = 4;
  localparam int unsigned CNT_W           = 16;

  typedef enum logic [2:0]
  {
    ST_OFF      = 3'b000,
    ST_REGS_UP  = 3'b001,
    ST_RESET    = 3'b010,
    ST_CONFIG   = 3'b011,
    ST_READY    = 3'b100
  } seq_state_e;

  typedef struct packed
  {
    logic supply_valid;
    logic supply_low;
    logic charger_ok;
    logic power_off_command;
  } sense_s;

  typedef struct packed
  {
    logic [NUM_REGS-1:0] regs_en;
    logic [NUM_IFS-1:0]  ifs_cfg;
    logic                pads_tristate;
    logic                core_reset;
    logic                ready;
    logic                charge_mode;
  } ctrl_s;

endpackage : pwr_seq_pkg

// >>> rtl/rtc_alarm.sv
// rtc time counter with a programmable alarm, driven by a 32.768 kHz tick
// assumes the tick is a one-cycle enable pulse in the clk_in domain
`timescale 1ns/1ns
module rtc_alarm
#(
  parameter int unsigned TIME_W = 32
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              tick_in,
  input  wire logic              alarm_set_in,
  input  wire logic [TIME_W-1:0] alarm_time_in,
  output logic                   alarm_out,
  output logic [TIME_W-1:0]      time_out
);
  import pwr_seq_pkg::*;

  logic [TIME_W-1:0] time_reg;
  logic [TIME_W-1:0] time_next;
  logic [TIME_W-1:0] alarm_reg;
  logic [TIME_W-1:0] alarm_next;
  logic              armed_reg;
  logic              armed_next;
  logic              hit_reg;
  logic              hit_next;

  // --------------------------------------------------------------
  // time and alarm
  // --------------------------------------------------------------
  always_comb
  begin
    time_next  = time_reg;
    alarm_next = alarm_reg;
    armed_next = armed_reg;
    hit_next   = 1'b0;
    if (tick_in)
    begin
      time_next = time_reg + 1'b1;
      if (armed_reg && (time_next == alarm_reg))
      begin
        hit_next   = 1'b1;
        armed_next = 1'b0;
      end
    end
    // a new alarm programmed in the same cycle replaces the spent one
    if (alarm_set_in)
    begin
      alarm_next = alarm_time_in;
      armed_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      time_reg  <= '0;
      alarm_reg <= '0;
      armed_reg <= 1'b0;
      hit_reg   <= 1'b0;
    end
    else
    begin
      time_reg  <= time_next;
      alarm_reg <= alarm_next;
      armed_reg <= armed_next;
      hit_reg   <= hit_next;
    end
  end

  assign alarm_out = hit_reg;
  assign time_out  = time_reg;

endmodule : rtc_alarm

// >>> rtl/power_on_sequencer.sv
// power-on sequencer: start-up event detection, regulator, reset and pad order
// assumes all inputs synchronous to clk_in; rtc kept alive by rst_in only
`timescale 1ns/1ns
module power_on_sequencer
#(
  parameter int unsigned TIME_W    = 32,
  parameter int unsigned RST_HOLD  = pwr_seq_pkg::RST_HOLD_CYC,
  parameter int unsigned REG_STEP  = pwr_seq_pkg::REG_STEP_CYC,
  parameter int unsigned CFG_STEP  = pwr_seq_pkg::CFG_STEP_CYC
)
(
  input  wire logic                              clk_in,
  input  wire logic                              rst_in,
  input  wire pwr_seq_pkg::sense_s               sense_in,
  input  wire logic                              power_on_request_low_in,
  input  wire logic                              alarm_set_in,
  input  wire logic [TIME_W-1:0]                 alarm_time_in,
  output pwr_seq_pkg::ctrl_s                     ctrl_out,
  output logic                                   reset_line_oe_out,
  output logic                                   reset_line_out,
  output logic                                   rtc_backup_supply_en_out,
  output logic                                   rtc_irq_out,
  output logic [TIME_W-1:0]                      rtc_time_out
);
  import pwr_seq_pkg::*;

  function automatic logic cnt_done(input logic [CNT_W-1:0] cnt,
                                    input int unsigned      lim);
    cnt_done = (cnt >= CNT_W'(lim - 1));
  endfunction : cnt_done

  // --------------------------------------------------------------
  // rtc tick divider
  // --------------------------------------------------------------
  logic [CNT_W-1:0] div_reg;
  logic [CNT_W-1:0] div_next;
  logic             tick_reg;
  logic             tick_next;

  always_comb
  begin
    div_next  = div_reg + 1'b1;
    tick_next = 1'b0;
    if (cnt_done(div_reg, RTC_DIV))
    begin
      div_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // --------------------------------------------------------------
  // rtc
  // --------------------------------------------------------------
  logic              alarm_hit;
  logic [TIME_W-1:0] rtc_time;

  rtc_alarm
  #(
    .TIME_W (TIME_W)
  )
  u_rtc
  (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .tick_in       (tick_reg),
    .alarm_set_in  (alarm_set_in),
    .alarm_time_in (alarm_time_in),
    .alarm_out     (alarm_hit),
    .time_out      (rtc_time)
  );

  // --------------------------------------------------------------
  // event qualification
  // --------------------------------------------------------------
  logic [CNT_W-1:0] req_cnt_reg;
  logic [CNT_W-1:0] req_cnt_next;
  logic             req_fired_reg;
  logic             req_fired_next;
  logic             was_low_reg;
  logic             was_low_next;
  logic             vld_d_reg;
  logic             chg_d_reg;
  logic             req_event;
  logic             vcc_event;
  logic             chg_event;

  always_comb
  begin
    req_cnt_next   = req_cnt_reg;
    req_fired_next = req_fired_reg;
    req_event      = 1'b0;
    // any return to high restarts the qualification
    if (power_on_request_low_in)
    begin
      req_cnt_next   = '0;
      req_fired_next = 1'b0;
    end
    else if (tick_reg && !req_fired_reg)
    begin
      if (cnt_done(req_cnt_reg, POWER_ON_REQUEST_LOW_TICKS))
      begin
        req_event      = 1'b1;
        req_fired_next = 1'b1;
      end
      else
      begin
        req_cnt_next = req_cnt_reg + 1'b1;
      end
    end
    // remember a dip below the low threshold until the supply is valid
    was_low_next = was_low_reg;
    if (sense_in.supply_low)
    begin
      was_low_next = 1'b1;
    end
    else if (sense_in.supply_valid)
    begin
      was_low_next = 1'b0;
    end
    vcc_event = sense_in.supply_valid && !vld_d_reg && was_low_reg;
    chg_event = sense_in.charger_ok && !chg_d_reg;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_cnt_reg   <= '0;
      req_fired_reg <= 1'b0;
      was_low_reg   <= 1'b1;
      vld_d_reg     <= 1'b0;
      chg_d_reg     <= 1'b0;
    end
    else
    begin
      req_cnt_reg   <= req_cnt_next;
      req_fired_reg <= req_fired_next;
      was_low_reg   <= was_low_next;
      vld_d_reg     <= sense_in.supply_valid;
      chg_d_reg     <= sense_in.charger_ok;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  seq_state_e          state_reg;
  seq_state_e          state_next;
  logic [CNT_W-1:0]    step_reg;
  logic [CNT_W-1:0]    step_next;
  logic [NUM_REGS-1:0] regs_reg;
  logic [NUM_REGS-1:0] regs_next;
  logic [NUM_IFS-1:0]  ifs_reg;
  logic [NUM_IFS-1:0]  ifs_next;
  logic                chg_mode_reg;
  logic                chg_mode_next;
  logic                irq_reg;
  logic                irq_next;
  logic                start;

  always_comb
  begin
    state_next    = state_reg;
    step_next     = step_reg + 1'b1;
    regs_next     = regs_reg;
    ifs_next      = ifs_reg;
    chg_mode_next = chg_mode_reg;
    irq_next      = alarm_hit;
    start         = sense_in.supply_valid &&
                    (vcc_event || req_event || alarm_hit || chg_event);
    case (state_reg)
      ST_OFF:
      begin
        step_next = '0;
        if (start)
        begin
          state_next    = ST_REGS_UP;
          chg_mode_next = chg_event && !req_event && !alarm_hit;
        end
      end
      ST_REGS_UP:
      begin
        // regulators come up one at a time, lowest first
        if (cnt_done(step_reg, REG_STEP))
        begin
          step_next = '0;
          regs_next = {regs_reg[NUM_REGS-2:0], 1'b1};
          if (&regs_reg[NUM_REGS-2:0])
          begin
            state_next = ST_RESET;
          end
        end
      end
      ST_RESET:
      begin
        if (cnt_done(step_reg, RST_HOLD))
        begin
          step_next  = '0;
          state_next = ST_CONFIG;
        end
      end
      ST_CONFIG:
      begin
        if (cnt_done(step_reg, CFG_STEP))
        begin
          step_next = '0;
          ifs_next  = {ifs_reg[NUM_IFS-2:0], 1'b1};
          if (&ifs_reg[NUM_IFS-2:0])
          begin
            state_next = ST_READY;
          end
        end
      end
      ST_READY:
      begin
        step_next = '0;
      end
      default:
      begin
        state_next = ST_OFF;
      end
    endcase
    // switch-off or supply loss ends in the power-off state
    if (sense_in.power_off_command || !sense_in.supply_valid)
    begin
      state_next    = ST_OFF;
      regs_next     = '0;
      ifs_next      = '0;
      chg_mode_next = 1'b0;
      step_next     = '0;
    end
    // other states ignore start: no restart mid-sequence
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg    <= ST_OFF;
      step_reg     <= '0;
      regs_reg     <= '0;
      ifs_reg      <= '0;
      chg_mode_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      step_reg     <= step_next;
      regs_reg     <= regs_next;
      ifs_reg      <= ifs_next;
      chg_mode_reg <= chg_mode_next;
      irq_reg      <= irq_next;
    end
  end

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  ctrl_s ctrl_reg;
  ctrl_s ctrl_next;
  logic  rst_oe_reg;
  logic  bkup_reg;
  logic  [TIME_W-1:0] time_reg;

  always_comb
  begin
    ctrl_next.regs_en       = regs_next;
    ctrl_next.ifs_cfg       = ifs_next;
    ctrl_next.pads_tristate = (state_next == ST_OFF) ||
                              (state_next == ST_REGS_UP);
    ctrl_next.core_reset    = (state_next != ST_CONFIG) &&
                              (state_next != ST_READY);
    ctrl_next.ready         = (state_next == ST_READY);
    ctrl_next.charge_mode   = chg_mode_next;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_reg   <= '{regs_en: '0, ifs_cfg: '0, pads_tristate: 1'b1,
                      core_reset: 1'b1, ready: 1'b0, charge_mode: 1'b0};
      rst_oe_reg <= 1'b1;
      bkup_reg   <= 1'b0;
      time_reg   <= '0;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      rst_oe_reg <= ctrl_next.core_reset;
      bkup_reg   <= sense_in.supply_valid;
      time_reg   <= rtc_time;
    end
  end

  // open drain: low only when enabled, the pull-up gives the high
  assign ctrl_out                 = ctrl_reg;
  assign reset_line_oe_out        = rst_oe_reg;
  assign reset_line_out           = 1'b0;
  assign rtc_backup_supply_en_out = bkup_reg;
  assign rtc_irq_out              = irq_reg;
  assign rtc_time_out             = time_reg;

endmodule : power_on_sequencer

// >>> bench/pwr_seq_properties.sv
// port checker for the power-on sequencer
// assumes it is bound onto power_on_sequencer; one clock domain
`timescale 1ns/1ns
module pwr_seq_properties
#(
  parameter int unsigned TIME_W = 32
)
(
  input wire logic                clk_in,
  input wire logic                rst_in,
  input wire pwr_seq_pkg::sense_s sense_in,
  input wire pwr_seq_pkg::ctrl_s  ctrl_out,
  input wire logic                reset_line_oe_out,
  input wire logic                reset_line_out,
  input wire logic                rtc_backup_supply_en_out,
  input wire logic                rtc_irq_out,
  input wire logic [TIME_W-1:0]   rtc_time_out
);
  import pwr_seq_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  pads_before_regs_a: assert property (
    !(&ctrl_out.regs_en) |-> ctrl_out.pads_tristate)
    else $error("pads driven before regulators up");
  reset_line_hold_a: assert property (
    ctrl_out.core_reset |-> reset_line_oe_out && !reset_line_out)
    else $error("reset line released during core reset");
  ready_after_cfg_a: assert property (
    ctrl_out.ready |-> &ctrl_out.ifs_cfg && !reset_line_oe_out)
    else $error("ready before all interfaces configured");
  cfg_in_order_a: assert property (
    |ctrl_out.ifs_cfg |-> !reset_line_oe_out
      && ctrl_out.ifs_cfg inside {4'h1, 4'h3, 4'h7, 4'hF})
    else $error("interface configured out of order");
  no_supply_off_a: assert property (
    !sense_in.supply_valid |=> ctrl_out.regs_en == 4'h0 && !ctrl_out.ready)
    else $error("powered without valid supply");
  backup_follows_a: assert property (
    1'b1 |=> rtc_backup_supply_en_out == $past(sense_in.supply_valid))
    else $error("backup regulator not following supply");
  switch_off_end_a: assert property (
    sense_in.power_off_command |=> ctrl_out.regs_en == 4'h0
      && ctrl_out.pads_tristate && reset_line_oe_out)
    else $error("switch-off end state wrong");
  irq_one_cycle_a: assert property (
    rtc_irq_out |=> !rtc_irq_out)
    else $error("rtc interrupt longer than a cycle");
  rtc_step_a: assert property (
    1'b1 |=> rtc_time_out == $past(rtc_time_out)
      || rtc_time_out == $past(rtc_time_out) + 1'b1)
    else $error("rtc time jumped");

  cover property (ctrl_out.ready && !ctrl_out.charge_mode);
  cover property (ctrl_out.ready && ctrl_out.charge_mode);
  cover property (rtc_irq_out);
endmodule : pwr_seq_properties

// >>> bench/push_button_model.sv
// push button on the active-low power-on request, with pull-up
// assumes press_in comes from the bench on rising edges
`timescale 1ns/1ns
module push_button_model
(
  input  wire logic clk_in,
  input  wire logic press_in,
  output logic      request_low_out
);
  logic held_reg;

  always_ff @(posedge clk_in)
    held_reg <= press_in;
  // the pull-up keeps a defined high level when released, never floating
  assign request_low_out = !held_reg;
endmodule : push_button_model

// >>> bench/tb_power_on_sequencer.sv
// self-checking bench for the power-on sequencer
// assumes a button model on the request pin and shortened step counts
`timescale 1ns/1ns
module tb_power_on_sequencer;
  import pwr_seq_pkg::*;
  localparam int unsigned TIME_W = 32;
  localparam int LAT = 4 * 2 + 4 + 4 * 2;
  logic              clk_in;
  logic              rst_in;
  sense_s            sense_in;
  logic              press;
  logic              req_low;
  logic              alarm_set_in;
  logic [TIME_W-1:0] alarm_time_in;
  ctrl_s             ctrl_out;
  logic              oe;
  logic              line;
  logic              bk_en;
  logic              irq;
  logic [TIME_W-1:0] rtime;
  int                n_fail;
  int                samples_checked;
  int                cyc;
  int                seed;
  int                lat;

  power_on_sequencer #(.TIME_W(TIME_W), .RST_HOLD(4), .REG_STEP(2), .CFG_STEP(2)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .sense_in(sense_in),
    .power_on_request_low_in(req_low), .alarm_set_in(alarm_set_in),
    .alarm_time_in(alarm_time_in), .ctrl_out(ctrl_out), .reset_line_oe_out(oe),
    .reset_line_out(line), .rtc_backup_supply_en_out(bk_en),
    .rtc_irq_out(irq), .rtc_time_out(rtime));
  push_button_model btn (.clk_in(clk_in), .press_in(press), .request_low_out(req_low));

  // ----------------------------------------
  // helpers and reference model
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc_n

  // 0 no start, 1 normal start, 2 charge-mode start
  function automatic int model_go(input bit ok, input bit rise, input bit chg, input bit alm);
    if (!ok)
      return 0;
    if (chg && !rise && !alm)
      return 2;
    return (rise || chg || alm) ? 1 : 0;
  endfunction : model_go

  task automatic attempt(input sense_s pre, input sense_s ev, input sense_s mid, input int exp);
    @(posedge clk_in);
    sense_in <= pre;
    cyc_n(3);
    sense_in <= ev;
    cyc_n(3);
    sense_in <= mid;
    if (exp == 0)
    begin
      cyc_n(100);
      @(negedge clk_in);
      check("regs_en", 0, ctrl_out.regs_en);
      check("ready", 0, ctrl_out.ready);
    end
    else
    begin
      lat = 0;
      while (ctrl_out.ready !== 1'b1 && lat < 200)
      begin
        @(negedge clk_in);
        lat++;
      end
      check("latency", 1, lat + 3 >= LAT && lat + 3 <= LAT + 5);
      check("charge_mode", exp == 2, ctrl_out.charge_mode);
      check("ifs_cfg", 4'hF, ctrl_out.ifs_cfg);
      check("reset_oe", 0, oe);
      check("backup_en", 1, bk_en);
      @(posedge clk_in);
      sense_in <= sense_s'(mid | 4'h1);
      @(posedge clk_in);
      sense_in <= mid;
      @(negedge clk_in);
      check("pads_off", 1, ctrl_out.pads_tristate);
      check("oe_off", 1, oe);
    end
    $display("test start case done");
  endtask : attempt

  task automatic alarm_case(input sense_s s);
    int n;
    logic [TIME_W-1:0] t;
    // take the time while it is settled, not in the edge that moves it
    t = rtime;
    @(posedge clk_in);
    sense_in <= s;
    alarm_time_in <= t + 32'h2;
    alarm_set_in <= 1'b1;
    @(posedge clk_in);
    alarm_set_in <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(negedge clk_in);
      n++;
    end
    check("rtc_irq", 1, irq);
    check("rtc_time", t + 32'h2, rtime);
    n = 0;
    while (ctrl_out.regs_en !== 4'hF && n < 100)
    begin
      @(negedge clk_in);
      n++;
    end
    check("alarm_regs", model_go(s.supply_valid, 0, 0, 1) ? 4'hF : 4'h0, ctrl_out.regs_en);
    @(posedge clk_in);
    sense_in <= sense_s'(4'h0);
    @(posedge clk_in);
    @(negedge clk_in);
    check("loss_off", 0, ctrl_out.regs_en);
    $display("test alarm done");
  endtask : alarm_case

  task automatic summarize();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    seed = 46;
    n_fail = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    sense_in = '0;
    press = 1'b0;
    alarm_set_in = 1'b0;
    alarm_time_in = '0;
    cyc_n(8);
    rst_in <= 1'b0;
    @(negedge clk_in);
    check("rst_pads", 1, ctrl_out.pads_tristate);
    check("rst_oe", 1, oe);
    check("rst_line", 0, line);
    check("rst_regs", 0, ctrl_out.regs_en);
    attempt(4'h4, 4'h8, 4'hA, model_go(1, 1, 0, 0));
    attempt(4'h8, 4'hA, 4'hA, model_go(1, 0, 1, 0));
    attempt(4'h0, 4'h2, 4'h2, model_go(0, 0, 1, 0));
    attempt(4'h0, 4'h8, 4'h8, model_go(1, 0, 0, 0));
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_in);
      press <= 1'b1;
      cyc_n(50 + ($unsigned($random(seed)) % 2000));
      press <= 1'b0;
      cyc_n(100);
      @(negedge clk_in);
      check("short_press", 0, ctrl_out.regs_en);
    end
    $display("test short press done");
    alarm_case(4'h8);
    alarm_case(4'h0);
    summarize();
  end
endmodule : tb_power_on_sequencer

bind power_on_sequencer pwr_seq_properties #(.TIME_W(TIME_W)) chk (
  .clk_in(clk_in), .rst_in(rst_in), .sense_in(sense_in), .ctrl_out(ctrl_out),
  .reset_line_oe_out(reset_line_oe_out), .reset_line_out(reset_line_out),
  .rtc_backup_supply_en_out(rtc_backup_supply_en_out),
  .rtc_irq_out(rtc_irq_out), .rtc_time_out(rtc_time_out));
